// ---- rwt_pkg.sv ----
package rwt_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [31:0] RWT_MODE_IDX      = 32'hFFFF_F090;
    localparam logic [31:0] RWT_CMD_IDX       = 32'hFFFF_F091;
    localparam logic [31:0] RWT_MODE_ADDR     = {RWT_MODE_IDX[29:0], 2'h0};
    localparam logic [31:0] RWT_CMD_ADDR      = {RWT_CMD_IDX[29:0], 2'h0};

    // ------------------------------------------------------------------
    // mode register fields
    // ------------------------------------------------------------------
    localparam int          RWT_ENABLE_POS    = 7;
    localparam int          RWT_PERIOD_HI     = 6;
    localparam int          RWT_PERIOD_LO     = 5;
    localparam int          RWT_IDLE_RUN_POS  = 2;
    localparam int          RWT_ACTION_POS    = 1;
    localparam int          RWT_SPARE_POS     = 0;
    localparam logic [7:0]  RWT_MODE_RESET    = 8'h80;
    localparam logic        RWT_ENABLE_RESET  = 1'h1;
    localparam logic [1:0]  RWT_PERIOD_RESET  = 2'h0;
    localparam logic        RWT_IDLE_RESET    = 1'h0;
    localparam logic        RWT_ACTION_RESET  = 1'h0;
    localparam logic        RWT_SPARE_RESET   = 1'h0;

    // ------------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------------
    localparam logic [7:0]  RWT_CODE_DISABLE  = 8'hB1;
    localparam logic [7:0]  RWT_CODE_CLEAR    = 8'h4E;

    // ------------------------------------------------------------------
    // counter and timing
    // ------------------------------------------------------------------
    localparam int          RWT_CNT_W         = 22;
    localparam int          RWT_TAP_BASE      = 15;
    localparam int          RWT_CLK_PERIOD_NS = 10;
    localparam int          RWT_RESET_STATES  = 32;
    localparam logic [5:0]  RWT_RESET_LAST    = 6'(RWT_RESET_STATES - 1);

    // ------------------------------------------------------------------
    // bus responses
    // ------------------------------------------------------------------
    localparam logic [1:0]  RWT_RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RWT_RESP_SLVERR   = 2'h2;

    typedef enum logic [1:0] {
        RWT_RUN   = 2'b01,
        RWT_RESET = 2'b10
    } rwt_state_e;

    typedef struct packed {
        rwt_state_e          fsm;
        logic [5:0]          rst_cnt;
        logic                half;
        logic [RWT_CNT_W-1:0] cnt;
        logic                active;
        logic                watch_enable_bit;
        logic [1:0]          detect_period_select;
        logic                idle_run_select;
        logic                overflow_action_select;
        logic                spare_bit;
        logic                overflow_nmi;
        logic                nmi_flag;
        logic                int_rst;
        logic                gear_fc8;
        logic                aw_held;
        logic [31:0]         aw_addr;
        logic                w_held;
        logic [7:0]          w_data;
        logic                w_strb0;
        logic                awready;
        logic                wready;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                arready;
        logic                rvalid;
        logic [31:0]         rdata;
        logic [1:0]          rresp;
    } rwt_regs_s;

endpackage

// ---- rwt_watchdog.sv ----
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps

// Functional notes
// - 22-stage counter advances at half system clock; taps at stages 15,17,19,21.
// - period field 00/01/10/11 picks 2^16/2^18/2^20/2^22 system clocks.
// - action bit 0 gives NMI on overflow, 1 gives internal chip reset; resets 0.
// - watchdog reset holds internal chip reset for 32 states.
// - during watchdog reset the clock gear is forced to oscillator divided by 8.
// - after reset enable is 1, period 00, idle-run 0, action 0.
// - disable only when enable bit already 0 and code B1H written.
// - writing enable bit 1 re-enables a disabled watchdog.
// - code 4EH clears the counter, counting continues.
// - code B1H also clears the counter.
// - command register is write-only and reads as zero.
// - counter starts counting right after chip reset is released.
// - in STOP mode counter held reset and idle.
// - counter keeps counting while bus is released, grant acknowledge low.
// - in IDLE counter stops if idle-run 0, counts if 1.
// - NMI from watchdog sets a dedicated source flag for software.
module rwt_watchdog
    import rwt_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [31:0] axi_awaddr,
    input  wire logic        axi_awvalid,
    output logic             axi_awready,
    input  wire logic [31:0] axi_wdata,
    input  wire logic [3:0]  axi_wstrb,
    input  wire logic        axi_wvalid,
    output logic             axi_wready,
    output logic [1:0]       axi_bresp,
    output logic             axi_bvalid,
    input  wire logic        axi_bready,
    input  wire logic [31:0] axi_araddr,
    input  wire logic        axi_arvalid,
    output logic             axi_arready,
    output logic [31:0]      axi_rdata,
    output logic [1:0]       axi_rresp,
    output logic             axi_rvalid,
    input  wire logic        axi_rready,
    input  wire logic        stop_mode,
    input  wire logic        idle_mode,
    input  wire logic        bus_grant_ack,
    input  wire logic        nmi_flag_clear,
    output logic             overflow_nmi,
    output logic             nmi_source_flag,
    output logic             internal_reset,
    output logic             clock_gear_fc8
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    rwt_regs_s          s;
    rwt_regs_s          next_s;

    logic               aw_ok;
    logic               w_ok;
    logic [31:0]        wr_addr;
    logic [7:0]         wr_data;
    logic               wr_strb0;
    logic               wr_go;
    logic               wr_mode;
    logic               wr_cmd;
    logic               cmd_clear;
    logic               cmd_disable;
    logic               run;
    logic               tick;
    logic [RWT_CNT_W-1:0] cnt_inc;
    logic [4:0]         tap_pos;
    logic               ovf;
    logic [7:0]         mode_byte;

    // ------------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------------
    assign aw_ok       = s.aw_held | (axi_awvalid & s.awready);
    assign w_ok        = s.w_held | (axi_wvalid & s.wready);
    assign wr_go       = aw_ok & w_ok & ~s.bvalid;
    assign wr_addr     = s.aw_held ? s.aw_addr : axi_awaddr;
    assign wr_data     = s.w_held ? s.w_data : axi_wdata[7:0];
    assign wr_strb0    = s.w_held ? s.w_strb0 : axi_wstrb[0];
    assign wr_mode     = wr_go & wr_strb0 & (wr_addr == RWT_MODE_ADDR);
    assign wr_cmd      = wr_go & wr_strb0 & (wr_addr == RWT_CMD_ADDR);
    assign cmd_clear   = wr_cmd & (wr_data == RWT_CODE_CLEAR);
    assign cmd_disable = wr_cmd & (wr_data == RWT_CODE_DISABLE);

    // ------------------------------------------------------------------
    // counter control
    // ------------------------------------------------------------------
    assign tick    = s.half;
    assign run     = s.active & ~stop_mode & (~idle_mode | s.idle_run_select)
                   & (s.fsm == RWT_RUN);
    assign cnt_inc = s.cnt + 1'b1;
    assign tap_pos = 5'(RWT_TAP_BASE) + {2'h0, s.detect_period_select, 1'b0};
    assign ovf     = run & tick & ~cmd_clear & ~cmd_disable & cnt_inc[tap_pos];

    assign mode_byte = {s.watch_enable_bit, s.detect_period_select, 2'h0,
                        s.idle_run_select, s.overflow_action_select, s.spare_bit};

    always_comb begin
        next_s              = s;
        next_s.half         = ~s.half;
        next_s.overflow_nmi = 1'b0;

        // ------------------------------------------------------------------
        // bus slave
        // ------------------------------------------------------------------
        if (axi_awvalid && s.awready) begin
            next_s.aw_held = 1'b1;
            next_s.aw_addr = axi_awaddr;
        end
        if (axi_wvalid && s.wready) begin
            next_s.w_held  = 1'b1;
            next_s.w_data  = axi_wdata[7:0];
            next_s.w_strb0 = axi_wstrb[0];
        end
        if (s.bvalid && axi_bready) begin
            next_s.bvalid = 1'b0;
        end
        if (wr_go) begin
            next_s.aw_held = 1'b0;
            next_s.w_held  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = (wr_addr == RWT_MODE_ADDR || wr_addr == RWT_CMD_ADDR)
                           ? RWT_RESP_OKAY : RWT_RESP_SLVERR;
        end
        next_s.awready = ~next_s.aw_held & ~next_s.bvalid;
        next_s.wready  = ~next_s.w_held & ~next_s.bvalid;

        if (s.rvalid && axi_rready) begin
            next_s.rvalid = 1'b0;
        end
        if (axi_arvalid && s.arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = RWT_RESP_OKAY;
            if (axi_araddr == RWT_MODE_ADDR) begin
                next_s.rdata = {24'h00_0000, mode_byte};
            end else if (axi_araddr == RWT_CMD_ADDR) begin
                next_s.rdata = 32'h0000_0000;
            end else begin
                next_s.rdata = 32'h0000_0000;
                next_s.rresp = RWT_RESP_SLVERR;
            end
        end
        next_s.arready = ~next_s.rvalid;

        // ------------------------------------------------------------------
        // mode and command effects
        // ------------------------------------------------------------------
        if (wr_mode) begin
            next_s.watch_enable_bit       = wr_data[RWT_ENABLE_POS];
            next_s.detect_period_select   = wr_data[RWT_PERIOD_HI:RWT_PERIOD_LO];
            next_s.idle_run_select        = wr_data[RWT_IDLE_RUN_POS];
            next_s.overflow_action_select = wr_data[RWT_ACTION_POS];
            next_s.spare_bit              = wr_data[RWT_SPARE_POS];
            if (wr_data[RWT_ENABLE_POS]) begin
                next_s.active = 1'b1;
            end
        end
        if (cmd_disable && !s.watch_enable_bit) begin
            next_s.active = 1'b0;
        end

        // ------------------------------------------------------------------
        // counter
        // ------------------------------------------------------------------
        if (stop_mode || !s.active || s.fsm == RWT_RESET) begin
            next_s.cnt = '0;
        end else if (cmd_clear || cmd_disable) begin
            next_s.cnt = '0;
        end else if (ovf) begin
            next_s.cnt = '0;
        end else if (run && tick) begin
            next_s.cnt = cnt_inc;
        end

        // ------------------------------------------------------------------
        // overflow action
        // ------------------------------------------------------------------
        if (nmi_flag_clear) begin
            next_s.nmi_flag = 1'b0;
        end
        if (ovf && !s.overflow_action_select) begin
            next_s.overflow_nmi = 1'b1;
            next_s.nmi_flag     = 1'b1;
        end

        unique case (s.fsm)
            RWT_RUN: begin
                if (ovf && s.overflow_action_select) begin
                    next_s.fsm      = RWT_RESET;
                    next_s.rst_cnt  = 6'h00;
                    next_s.int_rst  = 1'b1;
                    next_s.gear_fc8 = 1'b1;
                end
            end
            RWT_RESET: begin
                next_s.rst_cnt                = s.rst_cnt + 6'h01;
                next_s.watch_enable_bit       = RWT_ENABLE_RESET;
                next_s.detect_period_select   = RWT_PERIOD_RESET;
                next_s.idle_run_select        = RWT_IDLE_RESET;
                next_s.overflow_action_select = RWT_ACTION_RESET;
                next_s.spare_bit              = RWT_SPARE_RESET;
                next_s.active                 = RWT_ENABLE_RESET;
                if (s.rst_cnt == RWT_RESET_LAST) begin
                    next_s.fsm      = RWT_RUN;
                    next_s.int_rst  = 1'b0;
                    next_s.gear_fc8 = 1'b0;
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s                        <= '0;
            s.fsm                    <= RWT_RUN;
            s.active                 <= RWT_ENABLE_RESET;
            s.watch_enable_bit       <= RWT_ENABLE_RESET;
            s.detect_period_select   <= RWT_PERIOD_RESET;
            s.idle_run_select        <= RWT_IDLE_RESET;
            s.overflow_action_select <= RWT_ACTION_RESET;
            s.spare_bit              <= RWT_SPARE_RESET;
            s.awready                <= 1'b1;
            s.wready                 <= 1'b1;
            s.arready                <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign axi_awready     = s.awready;
    assign axi_wready      = s.wready;
    assign axi_bvalid      = s.bvalid;
    assign axi_bresp       = s.bresp;
    assign axi_arready     = s.arready;
    assign axi_rvalid      = s.rvalid;
    assign axi_rdata       = s.rdata;
    assign axi_rresp       = s.rresp;
    assign overflow_nmi    = s.overflow_nmi;
    assign nmi_source_flag = s.nmi_flag;
    assign internal_reset  = s.int_rst;
    assign clock_gear_fc8  = s.gear_fc8;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence rst_hold_seq;
        ##31 internal_reset ##1 !internal_reset;
    endsequence

    sequence rst_enter_seq;
        internal_reset && clock_gear_fc8 && (s.fsm == RWT_RESET);
    endsequence

    chk_reset_len: assert property ($rose(internal_reset) |-> rst_hold_seq)
        else $error("internal reset not held for 32 cycles");

    chk_reset_entry: assert property (ovf && s.overflow_action_select |=> rst_enter_seq)
        else $error("overflow in reset mode did not start reset");

    chk_nmi_raise: assert property (ovf && !s.overflow_action_select
                                    |=> overflow_nmi && nmi_source_flag && !internal_reset)
        else $error("overflow in nmi mode did not raise nmi and flag");

    chk_clear_code: assert property (cmd_clear |=> s.cnt == '0)
        else $error("clear code did not clear counter");

    chk_disable_code: assert property (cmd_disable && !s.watch_enable_bit && !wr_mode
                                       && s.fsm == RWT_RUN |=> !s.active ##0 s.cnt == '0)
        else $error("disable code with enable bit low did not disable");

    chk_disable_kept: assert property (cmd_disable && s.watch_enable_bit && s.active
                                       |=> s.active && s.cnt == '0)
        else $error("disable code with enable bit high changed enable state");

    chk_reenable: assert property (wr_mode && wr_data[RWT_ENABLE_POS] |=> s.active)
        else $error("enable bit write did not re-enable");

    chk_other_code: assert property (wr_cmd && !cmd_clear && !cmd_disable && !wr_mode
                                     && s.fsm == RWT_RUN |=> $stable(s.active))
        else $error("unknown command code changed enable state");

    chk_stop_hold: assert property (stop_mode |=> s.cnt == '0)
        else $error("counter not held in stop mode");

    chk_idle_stop: assert property (idle_mode && !s.idle_run_select && !wr_cmd
                                    |=> $stable(s.cnt))
        else $error("counter moved in idle with idle-run low");

    chk_idle_count: assert property (idle_mode && s.idle_run_select && s.active
                                     && !stop_mode && s.fsm == RWT_RUN |-> run)
        else $error("counter halted in idle with idle-run high");

    chk_count_busfree: assert property (run && tick && !ovf && !wr_cmd && !bus_grant_ack
                                        |=> s.cnt == $past(s.cnt) + 1'b1)
        else $error("counter did not advance while bus released");

    chk_tap_reach: assert property (run && tick && !wr_cmd && s.cnt == 22'h00_7FFF
                                    && s.detect_period_select == 2'h0 |-> ovf)
        else $error("shortest period did not overflow at its tap");

    chk_gear_follow: assert property (clock_gear_fc8 == internal_reset)
        else $error("clock gear request not aligned with internal reset");

    chk_nmi_pulse: assert property (overflow_nmi |=> !overflow_nmi)
        else $error("nmi pulse longer than one cycle");

    chk_flag_sticky: assert property (nmi_source_flag && !nmi_flag_clear
                                      |=> nmi_source_flag)
        else $error("nmi source flag dropped without clear");

    chk_count_start: assert property ($fell(internal_reset) && !stop_mode && !idle_mode
                                      |-> run)
        else $error("counter not running after internal reset");

    chk_mode_restore: assert property ($fell(internal_reset) |-> mode_byte == RWT_MODE_RESET)
        else $error("mode register not restored by internal reset");

    // ------------------------------------------------------------------
    // bus checks
    // ------------------------------------------------------------------
    chk_cmd_read: assert property (axi_arvalid && axi_arready && axi_araddr == RWT_CMD_ADDR
                                   |=> axi_rvalid && axi_rdata == 32'h0000_0000)
        else $error("command register did not read as zero");

    chk_bresp_hold: assert property (axi_bvalid && !axi_bready
                                     |=> axi_bvalid && $stable(axi_bresp))
        else $error("write response changed before handshake");

    chk_rdata_hold: assert property (axi_rvalid && !axi_rready
                                     |=> axi_rvalid && $stable(axi_rdata))
        else $error("read data changed before handshake");

    chk_write_busy: assert property (axi_bvalid |-> !axi_awready && !axi_wready)
        else $error("write channel ready while response pending");

    chk_read_busy: assert property (axi_rvalid |-> !axi_arready)
        else $error("read address ready while data pending");

endmodule

// ---- rwt_partner.sv ----
`timescale 1ns/1ps
// --------------------------
// interrupt controller model
// --------------------------
module rwt_partner
    import rwt_pkg::*;
#(
    parameter int ACK_DELAY = 5
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [31:0] cyc,
    input  wire logic        overflow_nmi,
    input  wire logic        nmi_source_flag,
    output logic             nmi_flag_clear,
    output logic [7:0]       nmi_count,
    output logic [31:0]      nmi_cycle,
    output logic [7:0]       flag_reads
);
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            nmi_flag_clear <= 1'b0;
            nmi_count      <= 8'h00;
            nmi_cycle      <= 32'h0000_0000;
            flag_reads     <= 8'h00;
        end else begin
            nmi_flag_clear <= nmi_source_flag && !nmi_flag_clear
                              && (flag_reads == 8'(ACK_DELAY));
            if (overflow_nmi) begin
                nmi_count <= nmi_count + 8'h01;
                nmi_cycle <= cyc;
            end
            // handler polls the source flag, then acknowledges it
            if (nmi_source_flag && !nmi_flag_clear) begin
                flag_reads <= flag_reads + 8'h01;
            end
        end
    end
endmodule

// ---- tb_runaway_watchdog_timer.sv ----
`timescale 1ns/1ps
// -------------
// testbench top
// -------------
module tb_runaway_watchdog_timer
    import rwt_pkg::*;
;
    localparam logic [31:0] PERIOD_CYC = 32'h0000_0001 << (RWT_TAP_BASE + 1);
    localparam int          PAUSE      = 32'h0000_0BB8;
    logic        ref_clk       = 1'b0;
    logic        rst           = 1'b1;
    logic [31:0] axi_awaddr    = 32'h0000_0000;
    logic [31:0] axi_wdata     = 32'h0000_0000;
    logic [31:0] axi_araddr    = 32'h0000_0000;
    logic [3:0]  axi_wstrb     = 4'hF;
    logic        axi_awvalid   = 1'b0;
    logic        axi_wvalid    = 1'b0;
    logic        axi_bready    = 1'b0;
    logic        axi_arvalid   = 1'b0;
    logic        axi_rready    = 1'b0;
    logic        stop_mode     = 1'b0;
    logic        idle_mode     = 1'b0;
    logic        bus_grant_ack = 1'b1;
    logic        axi_awready, axi_wready, axi_bvalid, axi_arready, axi_rvalid;
    logic [1:0]  axi_bresp, axi_rresp;
    logic [31:0] axi_rdata, nmi_cycle;
    logic        nmi_flag_clear, overflow_nmi, nmi_source_flag, internal_reset, clock_gear_fc8;
    logic [7:0]  nmi_count, flag_reads;
    logic        ires_seen     = 1'b0;
    logic [31:0] cyc           = 32'h0000_0000;
    logic [31:0] clear_cyc     = 32'h0000_0000;
    int          err_count     = 0;
    int          samples_checked = 0;

    always #5 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        cyc <= cyc + 32'h0000_0001;
        if (internal_reset === 1'b1 || clock_gear_fc8 === 1'b1) begin
            ires_seen <= 1'b1;
        end
    end

    rwt_watchdog u_rwt_watchdog (
        .ref_clk(ref_clk), .rst(rst), .axi_awaddr(axi_awaddr), .axi_awvalid(axi_awvalid),
        .axi_awready(axi_awready), .axi_wdata(axi_wdata), .axi_wstrb(axi_wstrb),
        .axi_wvalid(axi_wvalid), .axi_wready(axi_wready), .axi_bresp(axi_bresp),
        .axi_bvalid(axi_bvalid), .axi_bready(axi_bready), .axi_araddr(axi_araddr),
        .axi_arvalid(axi_arvalid), .axi_arready(axi_arready), .axi_rdata(axi_rdata),
        .axi_rresp(axi_rresp), .axi_rvalid(axi_rvalid), .axi_rready(axi_rready),
        .stop_mode(stop_mode), .idle_mode(idle_mode), .bus_grant_ack(bus_grant_ack),
        .nmi_flag_clear(nmi_flag_clear), .overflow_nmi(overflow_nmi),
        .nmi_source_flag(nmi_source_flag), .internal_reset(internal_reset),
        .clock_gear_fc8(clock_gear_fc8)
    );

    rwt_partner #(.ACK_DELAY(5)) u_rwt_partner (
        .ref_clk(ref_clk), .rst(rst), .cyc(cyc), .overflow_nmi(overflow_nmi),
        .nmi_source_flag(nmi_source_flag), .nmi_flag_clear(nmi_flag_clear),
        .nmi_count(nmi_count), .nmi_cycle(nmi_cycle), .flag_reads(flag_reads)
    );

    // -------------
    // shared tasks
    // -------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one bus write or read, response and read data compared
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [7:0] d,
                        input logic [31:0] ed, input logic [1:0] er);
        logic [31:0] rd;
        logic [1:0]  rs;
        rd = ~ed;
        rs = 2'h3;
        @(posedge ref_clk);
        axi_awaddr  <= a;
        axi_araddr  <= a;
        axi_wdata   <= {24'h00_0000, d};
        axi_awvalid <= wr;
        axi_wvalid  <= wr;
        axi_bready  <= wr;
        axi_arvalid <= !wr;
        axi_rready  <= !wr;
        for (int n = 0; n < 50; n++) begin
            @(posedge ref_clk);
            if (axi_awready === 1'b1) axi_awvalid <= 1'b0;
            if (axi_wready === 1'b1) axi_wvalid <= 1'b0;
            if (axi_arready === 1'b1) axi_arvalid <= 1'b0;
            if (axi_bvalid === 1'b1 || axi_rvalid === 1'b1) begin
                rd = wr ? ed : axi_rdata;
                rs = wr ? axi_bresp : axi_rresp;
                axi_bready <= 1'b0;
                axi_rready <= 1'b0;
                break;
            end
        end
        check("bus data", rd, ed);
        check("bus response", {30'h0000_0000, rs}, {30'h0000_0000, er});
    endtask

    task automatic conclude();
        if (err_count == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ---------
    // scenarios
    // ---------
    task automatic t_registers();
        xfer(1'b0, RWT_MODE_ADDR, 8'h00, {24'h00_0000, RWT_MODE_RESET}, RWT_RESP_OKAY);
        xfer(1'b0, RWT_CMD_ADDR, 8'h00, 32'h0000_0000, RWT_RESP_OKAY);
        xfer(1'b1, RWT_MODE_ADDR, 8'h7F, 32'h0000_0000, RWT_RESP_OKAY);
        xfer(1'b0, RWT_MODE_ADDR, 8'h00, 32'h0000_0067, RWT_RESP_OKAY);
        xfer(1'b0, 32'h0000_0010, 8'h00, 32'h0000_0000, RWT_RESP_SLVERR);
        xfer(1'b1, 32'h0000_0010, RWT_CODE_CLEAR, 32'h0000_0000, RWT_RESP_SLVERR);
    endtask

    task automatic t_disable();
        xfer(1'b1, RWT_MODE_ADDR, 8'h00, 32'h0000_0000, RWT_RESP_OKAY);
        xfer(1'b1, RWT_CMD_ADDR, RWT_CODE_DISABLE, 32'h0000_0000, RWT_RESP_OKAY);
        xfer(1'b0, RWT_MODE_ADDR, 8'h00, 32'h0000_0000, RWT_RESP_OKAY);
        repeat (3000) @(posedge ref_clk);
    endtask

    task automatic t_enable_clear();
        xfer(1'b1, RWT_MODE_ADDR, RWT_MODE_RESET, 32'h0000_0000, RWT_RESP_OKAY);
        repeat (2000) @(posedge ref_clk);
        stop_mode <= 1'b1;
        repeat (100) @(posedge ref_clk);
        stop_mode <= 1'b0;
        xfer(1'b1, RWT_CMD_ADDR, RWT_CODE_DISABLE, 32'h0000_0000, RWT_RESP_OKAY);
        repeat (2000) @(posedge ref_clk);
        xfer(1'b1, RWT_CMD_ADDR, RWT_CODE_CLEAR, 32'h0000_0000, RWT_RESP_OKAY);
        clear_cyc = cyc;
    endtask

    // stray codes, idle with and without counting, bus released
    task automatic t_modes();
        logic [7:0] junk [4];
        junk = '{8'h00, 8'h4F, 8'hB0, 8'hFF};
        repeat (10000) @(posedge ref_clk);
        foreach (junk[i]) begin
            xfer(1'b1, RWT_CMD_ADDR, junk[i], 32'h0000_0000, RWT_RESP_OKAY);
        end
        idle_mode <= 1'b1;
        repeat (PAUSE) @(posedge ref_clk);
        idle_mode <= 1'b0;
        xfer(1'b1, RWT_MODE_ADDR, 8'h84, 32'h0000_0000, RWT_RESP_OKAY);
        idle_mode <= 1'b1;
        repeat (PAUSE) @(posedge ref_clk);
        idle_mode <= 1'b0;
        bus_grant_ack <= 1'b0;
        repeat (PAUSE) @(posedge ref_clk);
        bus_grant_ack <= 1'b1;
    endtask

    task automatic t_overflow();
        logic [31:0] exp_cyc;
        exp_cyc = clear_cyc + PERIOD_CYC + 32'(PAUSE);
        while (cyc < exp_cyc + 32'h0000_0020) @(posedge ref_clk);
        check("nmi count", {24'h00_0000, nmi_count}, 32'h0000_0001);
        check("nmi early", {31'h0, nmi_cycle + 32'h0000_0008 < exp_cyc}, 32'h0000_0000);
        check("nmi late", {31'h0, nmi_cycle > exp_cyc + 32'h0000_0008}, 32'h0000_0000);
        check("flag polls", {24'h00_0000, flag_reads}, 32'h0000_0006);
        check("flag cleared", {31'h0, nmi_source_flag}, 32'h0000_0000);
        check("no chip reset", {31'h0, ires_seen}, 32'h0000_0000);
    endtask

    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        t_registers();
        t_disable();
        t_enable_clear();
        t_modes();
        t_overflow();
        conclude();
    end

    initial begin
        repeat (90000) @(posedge ref_clk);
        err_count++;
        conclude();
    end
endmodule
